// ---- rtl/fis_pkg.sv ----
// Constants and types shared by the operand input front end
//
// Overview of operation
// - Operands arrive on two 32-bit buses, usable together as one 64-bit bus.
// - Bus data goes to a 64-bit staging register or straight to operands.
// - Staging upper half takes the first bus, lower half the second bus.
// - Staging captures on rising edge when edge select low, falling when high.
// - Byte granularity computes a parity bit per byte and compares it.
// - A byte's parity bit is high exactly when it holds odd ones.
// - Each bus has its own parity group; bit zero covers the low byte.
// - Any failing byte of a bus raises that bus's own fault output.
// - Word granularity checks one bit over the word, on parity bit zero.
// - Input registers can be switched out so data flows straight through.
// - Operand registers load on the rising edge, halves picked by routing.
// - Bypass low makes operand registers clocked; high makes them transparent.
package fis_pkg;

  // Data widths
  localparam int WORD_W  = 32;
  localparam int QUAD_W  = 64;
  localparam int NBYTES  = 4;
  localparam int REG_AW  = 8;

  // Register byte offsets
  localparam logic [REG_AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] ADDR_CLEAR  = 8'h08;
  localparam logic [REG_AW-1:0] ADDR_ENABLE = 8'h0c;

  // Control register fields and reset value
  localparam int CTRL_W          = 5;
  localparam int CTRL_GRAN_BIT   = 0;
  localparam int CTRL_EDGE_BIT   = 1;
  localparam int CTRL_ROUTE_LSB  = 2;
  localparam int CTRL_BYPASS_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

  // Event bits of status, clear and enable registers
  localparam int NEV       = 2;
  localparam int EV_FIRST  = 0;
  localparam int EV_SECOND = 1;
  localparam logic [NEV-1:0] EV_RESET = 2'h0;

  // Bus codes
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic       HRESP_OKAY  = 1'h0;

  // Input routing select codes
  typedef enum logic [1:0] {
    ROUTE_A_BUSES  = 2'b00,
    ROUTE_SINGLE   = 2'b01,
    ROUTE_LOW_BUS  = 2'b10,
    ROUTE_B_BUSES  = 2'b11
  } fis_route_e;

  // Read sequencer states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_WAIT = 2'b10
  } fis_rd_e;

endpackage

// ---- rtl/fis_parity.sv ----
// Even parity checker for one operand bus
`timescale 1ns/1ps
module fis_parity (
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // Mode
  input  wire logic                       gran_in,
  // Bus and parity
  input  wire logic [fis_pkg::WORD_W-1:0] data_in,
  input  wire logic [fis_pkg::NBYTES-1:0] parity_in,
  // Result
  output logic                            fault_out
);
  import fis_pkg::*;

  logic [NBYTES-1:0] byte_miss;
  logic              word_miss;

  // Odd count of ones gives a high parity bit
  function automatic logic odd_ones(input logic [WORD_W-1:0] v);
    odd_ones = ^v;
  endfunction

  // Per byte compare, bit i covers byte i
  genvar i;
  generate
    for (i = 0; i < NBYTES; i++) begin : g_byte
      assign byte_miss[i] = odd_ones({24'h0, data_in[8*i +: 8]}) ^
                            parity_in[i];
    end
  endgenerate

  // Whole word check uses the lowest parity bit only
  assign word_miss = odd_ones(data_in) ^ parity_in[0];
  assign fault_out = gran_in ? |byte_miss : word_miss;

  property p_word_ok;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!gran_in && (odd_ones(data_in) == parity_in[0])) |-> !fault_out;
  endproperty
  a_word_ok: assert property (p_word_ok)
    else $error("word parity fault raised on matching parity");

  property p_word_upper_ignored;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!gran_in && $past(!gran_in) && $stable(data_in) &&
       $stable(parity_in[0])) |-> $stable(fault_out);
  endproperty
  a_word_upper_ignored: assert property (p_word_upper_ignored)
    else $error("upper parity bits affected word check");

  property p_byte_flip;
    @(posedge ref_clk_in) disable iff (rst_in)
      (gran_in && $past(gran_in) && $stable(data_in) &&
       $past(!fault_out) && (parity_in[NBYTES-1] != $past(parity_in[NBYTES-1])))
      |-> fault_out;
  endproperty
  a_byte_flip: assert property (p_byte_flip)
    else $error("flipped byte parity not flagged");

  property p_no_memory;
    @(posedge ref_clk_in) disable iff (rst_in)
      ($past(fault_out) && !gran_in && (odd_ones(data_in) == parity_in[0]))
      |-> !fault_out;
  endproperty
  a_no_memory: assert property (p_no_memory)
    else $error("fault held after clean data");

endmodule

// ---- rtl/fis_stage.sv ----
// Staging register with selectable capture edge
`timescale 1ns/1ps
module fis_stage (
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // Capture edge select, high picks the falling edge
  input  wire logic                       edge_sel_in,
  // Operand buses
  input  wire logic [fis_pkg::WORD_W-1:0] bus_first_in,
  input  wire logic [fis_pkg::WORD_W-1:0] bus_second_in,
  // Staged value
  output logic      [fis_pkg::QUAD_W-1:0] staged_out
);
  import fis_pkg::*;

  logic [QUAD_W-1:0] stage_rise;
  logic [QUAD_W-1:0] stage_fall;

  // Rising edge copy, first bus in upper half
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage_rise <= '0;
    end else begin
      stage_rise <= {bus_first_in, bus_second_in};
    end
  end

  // Falling edge copy so a second half enters within one cycle
  always_ff @(negedge ref_clk_in) begin
    if (rst_in) begin
      stage_fall <= '0;
    end else begin
      stage_fall <= {bus_first_in, bus_second_in};
    end
  end

  // Edge select picks which copy is the staging register
  assign staged_out = edge_sel_in ? stage_fall : stage_rise;

  property p_rise_capture;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!edge_sel_in && $past(!rst_in)) |->
        (staged_out == {$past(bus_first_in), $past(bus_second_in)});
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("rising edge staging mismatch");

  property p_fall_capture;
    @(posedge ref_clk_in) disable iff (rst_in)
      (edge_sel_in && $past(!rst_in) && $stable(bus_first_in) &&
       $stable(bus_second_in)) |->
        (staged_out == {bus_first_in, bus_second_in});
  endproperty
  a_fall_capture: assert property (p_fall_capture)
    else $error("falling edge staging mismatch");

endmodule

// ---- rtl/fis_top.sv ----
// Operand input front end: parity check, staging, operand registers
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fis_top (
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // AHB-Lite slave
  input  wire logic                       hsel_in,
  input  wire logic [31:0]                haddr_in,
  input  wire logic [1:0]                 htrans_in,
  input  wire logic                       hwrite_in,
  input  wire logic [2:0]                 hsize_in,
  input  wire logic [31:0]                hwdata_in,
  input  wire logic                       hready_in,
  output logic      [31:0]                hrdata_out,
  output logic                            hreadyout_out,
  output logic                            hresp_out,
  // Interrupt
  output logic                            irq_out,
  // Operand buses and their parity
  input  wire logic [fis_pkg::WORD_W-1:0] operand_bus_first_in,
  input  wire logic [fis_pkg::WORD_W-1:0] operand_bus_second_in,
  input  wire logic [fis_pkg::NBYTES-1:0] first_bus_parity_in,
  input  wire logic [fis_pkg::NBYTES-1:0] second_bus_parity_in,
  // Parity faults
  output logic                            first_bus_parity_fault_out,
  output logic                            second_bus_parity_fault_out,
  // Operands toward the arithmetic units
  output logic      [fis_pkg::QUAD_W-1:0] operand_reg_first_out,
  output logic      [fis_pkg::QUAD_W-1:0] operand_reg_second_out,
  output logic      [fis_pkg::QUAD_W-1:0] staged_out
);
  import fis_pkg::*;

  // Control and event registers
  logic [CTRL_W-1:0] ctrl;
  logic [NEV-1:0]    status;
  logic [NEV-1:0]    enable;
  logic [NEV-1:0]    next_status;
  logic [NEV-1:0]    events;

  // Bus pipeline state
  logic              wr_pend;
  logic [REG_AW-1:0] wr_addr;
  logic [REG_AW-1:0] rd_addr;
  fis_rd_e           rd_state;
  fis_rd_e           next_rd_state;
  logic [31:0]       next_hrdata;

  // Datapath
  logic              parity_granularity_select;
  logic              staging_edge_select;
  logic              input_stage_bypass;
  fis_route_e        input_routing_select;
  logic [QUAD_W-1:0] staged;
  logic [QUAD_W-1:0] operand_reg_first;
  logic [QUAD_W-1:0] operand_reg_second;
  logic [QUAD_W-1:0] next_operand_reg_first;
  logic [QUAD_W-1:0] next_operand_reg_second;
  logic [WORD_W-1:0] upper_half;
  logic [WORD_W-1:0] lower_half;

  // Address phase decode
  wire              bus_take = hsel_in & htrans_in[1] & hready_in;
  wire              rd_take  = bus_take & ~hwrite_in;
  wire [REG_AW-1:0] a_off    = haddr_in[REG_AW-1:0];
  wire              wr_ctrl  = wr_pend & (wr_addr == ADDR_CTRL);
  wire              wr_clear = wr_pend & (wr_addr == ADDR_CLEAR);
  wire              wr_en    = wr_pend & (wr_addr == ADDR_ENABLE);

  // Control fields steering the datapath
  assign parity_granularity_select = ctrl[CTRL_GRAN_BIT];
  assign staging_edge_select       = ctrl[CTRL_EDGE_BIT];
  assign input_stage_bypass        = ctrl[CTRL_BYPASS_BIT];
  assign input_routing_select      =
    fis_route_e'(ctrl[CTRL_ROUTE_LSB +: 2]);

  // Parity check of each bus on its own parity group
  fis_parity u_par_first (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .gran_in    (parity_granularity_select),
    .data_in    (operand_bus_first_in),
    .parity_in  (first_bus_parity_in),
    .fault_out  (first_bus_parity_fault_out)
  );

  fis_parity u_par_second (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .gran_in    (parity_granularity_select),
    .data_in    (operand_bus_second_in),
    .parity_in  (second_bus_parity_in),
    .fault_out  (second_bus_parity_fault_out)
  );

  // Staging register over both buses
  fis_stage u_stage (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .edge_sel_in   (staging_edge_select),
    .bus_first_in  (operand_bus_first_in),
    .bus_second_in (operand_bus_second_in),
    .staged_out    (staged)
  );

  assign upper_half = staged[QUAD_W-1:WORD_W];
  assign lower_half = staged[WORD_W-1:0];
  assign staged_out = staged;

  // Operand half selection from buses and staging register
  always_comb begin
    unique case (input_routing_select)
      ROUTE_A_BUSES: begin
        next_operand_reg_first  = {operand_bus_first_in,
                                   operand_bus_second_in};
        next_operand_reg_second = staged;
      end
      ROUTE_SINGLE: begin
        next_operand_reg_first  = {operand_bus_first_in, upper_half};
        next_operand_reg_second = {operand_bus_second_in, lower_half};
      end
      ROUTE_LOW_BUS: begin
        next_operand_reg_first  = {upper_half, operand_bus_first_in};
        next_operand_reg_second = {lower_half, operand_bus_second_in};
      end
      ROUTE_B_BUSES: begin
        next_operand_reg_first  = staged;
        next_operand_reg_second = {operand_bus_first_in,
                                   operand_bus_second_in};
      end
    endcase
  end

  // Operand registers load on every rising edge
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      operand_reg_first  <= '0;
      operand_reg_second <= '0;
    end else begin
      operand_reg_first  <= next_operand_reg_first;
      operand_reg_second <= next_operand_reg_second;
    end
  end

  // Bypass makes the operand stage flow through
  assign operand_reg_first_out  = input_stage_bypass ?
    next_operand_reg_first : operand_reg_first;
  assign operand_reg_second_out = input_stage_bypass ?
    next_operand_reg_second : operand_reg_second;

  // Fault events, set wins over a clear in the same cycle
  assign events[EV_FIRST]  = first_bus_parity_fault_out;
  assign events[EV_SECOND] = second_bus_parity_fault_out;
  assign next_status = (status & ~(wr_clear ? hwdata_in[NEV-1:0] : '0))
                       | events;
  assign irq_out = |(status & enable);

  // Write data phase commits to the addressed register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl   <= CTRL_RESET;
      enable <= EV_RESET;
      status <= EV_RESET;
    end else begin
      status <= next_status;
      if (wr_ctrl) begin
        ctrl <= hwdata_in[CTRL_W-1:0];
      end
      if (wr_en) begin
        enable <= hwdata_in[NEV-1:0];
      end
    end
  end

  // Address phase capture for writes and reads
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      rd_addr <= '0;
    end else begin
      wr_pend <= bus_take & hwrite_in;
      wr_addr <= a_off;
      if (rd_take) begin
        rd_addr <= a_off;
      end
    end
  end

  // Read mux, unmapped and write-only offsets read zero
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (rd_addr == ADDR_CTRL) begin
      next_hrdata[CTRL_W-1:0] = ctrl;
    end else if (rd_addr == ADDR_STATUS) begin
      next_hrdata[NEV-1:0] = status;
    end else if (rd_addr == ADDR_ENABLE) begin
      next_hrdata[NEV-1:0] = enable;
    end
  end

  // One wait state lets a preceding write land before a read
  always_comb begin
    unique case (rd_state)
      RD_IDLE: next_rd_state = rd_take ? RD_WAIT : RD_IDLE;
      RD_WAIT: next_rd_state = RD_IDLE;
      default: next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_state   <= RD_IDLE;
      hrdata_out <= 32'h0000_0000;
    end else begin
      rd_state <= next_rd_state;
      if (rd_state == RD_WAIT) begin
        hrdata_out <= next_hrdata;
      end
    end
  end

  assign hreadyout_out = (rd_state != RD_WAIT);
  assign hresp_out     = HRESP_OKAY;

  // Single precision routing loads A and B upper halves from the buses
  sequence s_single_load;
    (input_routing_select == ROUTE_SINGLE) && !input_stage_bypass;
  endsequence

  property p_single_route;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_single_load ##1 !input_stage_bypass |->
        (operand_reg_first_out[QUAD_W-1:WORD_W] ==
           $past(operand_bus_first_in)) &&
        (operand_reg_second_out[QUAD_W-1:WORD_W] ==
           $past(operand_bus_second_in));
  endproperty
  a_single_route: assert property (p_single_route)
    else $error("single precision operand load mismatch");

  property p_b_from_buses;
    @(posedge ref_clk_in) disable iff (rst_in)
      (input_routing_select == ROUTE_B_BUSES) && !input_stage_bypass
      ##1 !input_stage_bypass |->
        operand_reg_second_out ==
          {$past(operand_bus_first_in), $past(operand_bus_second_in)};
  endproperty
  a_b_from_buses: assert property (p_b_from_buses)
    else $error("operand B not loaded from both buses");

  property p_bypass_flow;
    @(posedge ref_clk_in) disable iff (rst_in)
      (input_stage_bypass && input_routing_select == ROUTE_A_BUSES) |->
        operand_reg_first_out ==
          {operand_bus_first_in, operand_bus_second_in};
  endproperty
  a_bypass_flow: assert property (p_bypass_flow)
    else $error("bypass did not pass bus data through");

  property p_fault_sticky;
    @(posedge ref_clk_in) disable iff (rst_in)
      first_bus_parity_fault_out |=> status[EV_FIRST];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("first bus fault not recorded");

  property p_read_wait;
    @(posedge ref_clk_in) disable iff (rst_in)
      rd_take |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer not one wait state");

  // Writes complete with no wait state
  property p_write_no_wait;
    @(posedge ref_clk_in) disable iff (rst_in)
      (bus_take && hwrite_in) |=> hreadyout_out;
  endproperty
  a_write_no_wait: assert property (p_write_no_wait)
    else $error("write data phase stalled");

  // Pair routing takes A from both buses and B from the staging register
  sequence s_pair_load;
    (input_routing_select == ROUTE_A_BUSES) && !input_stage_bypass;
  endsequence

  property p_a_from_buses;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_pair_load ##1 !input_stage_bypass |->
        (operand_reg_first_out ==
           {$past(operand_bus_first_in), $past(operand_bus_second_in)}) &&
        (operand_reg_second_out == $past(staged));
  endproperty
  a_a_from_buses: assert property (p_a_from_buses)
    else $error("pair routing operand load mismatch");

  // Low half routing puts the bus words in the operand low halves
  property p_low_route;
    @(posedge ref_clk_in) disable iff (rst_in)
      (input_routing_select == ROUTE_LOW_BUS) && !input_stage_bypass
      ##1 !input_stage_bypass |->
        (operand_reg_first_out[WORD_W-1:0] ==
           $past(operand_bus_first_in)) &&
        (operand_reg_second_out[WORD_W-1:0] ==
           $past(operand_bus_second_in));
  endproperty
  a_low_route: assert property (p_low_route)
    else $error("low half routing operand load mismatch");

  // A second bus fault leaves its own sticky status bit
  property p_second_sticky;
    @(posedge ref_clk_in) disable iff (rst_in)
      second_bus_parity_fault_out |=> status[EV_SECOND];
  endproperty
  a_second_sticky: assert property (p_second_sticky)
    else $error("second bus fault not recorded");

endmodule

// ---- tb/fis_host_model.sv ----
// Host datapath model that drives the operand buses and their parity
`timescale 1ns/1ps
module fis_host_model (
  // Operand buses
  output logic [fis_pkg::WORD_W-1:0] bus_first_out,
  output logic [fis_pkg::WORD_W-1:0] bus_second_out,
  // Parity groups, bit zero covers the low byte
  output logic [fis_pkg::NBYTES-1:0] par_first_out,
  output logic [fis_pkg::NBYTES-1:0] par_second_out
);
  import fis_pkg::*;

  // Even parity per byte, or one bit over the word on bit zero
  function automatic logic [NBYTES-1:0] parity_of(
    input logic [WORD_W-1:0] d,
    input logic              gran
  );
    logic [NBYTES-1:0] p;
    for (int i = 0; i < NBYTES; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    if (!gran) begin
      p    = ~p;           // Spare bits carry junk so they must be ignored
      p[0] = ^d;
    end
    return p;
  endfunction

  // Called just after a rising edge; flip masks corrupt chosen bits
  task automatic drive(
    input logic [WORD_W-1:0] first,
    input logic [WORD_W-1:0] second,
    input logic              gran,
    input logic [NBYTES-1:0] flip_first,
    input logic [NBYTES-1:0] flip_second
  );
    bus_first_out  <= first;
    bus_second_out <= second;
    par_first_out  <= parity_of(first, gran) ^ flip_first;
    par_second_out <= parity_of(second, gran) ^ flip_second;
  endtask

  // Clean zero words until the bench takes over
  initial begin
    drive(32'h0, 32'h0, 1'b0, 4'h0, 4'h0);
  end
endmodule

// ---- tb/tb.sv ----
// Testbench for the operand input front end
`timescale 1ns/1ps
module tb;
  import fis_pkg::*;

  logic         ref_clk;
  logic         rst;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic         irq;
  logic [31:0]  bus_first;
  logic [31:0]  bus_second;
  logic [3:0]   par_first;
  logic [3:0]   par_second;
  logic         fault_first;
  logic         fault_second;
  logic [63:0]  op_first;
  logic [63:0]  op_second;
  logic [63:0]  staged;
  logic [127:0] exp_ops;
  int           failures;
  int           checks;

  // Free running clock
  always #5 ref_clk = ~ref_clk;

  fis_host_model host (
    .bus_first_out  (bus_first),
    .bus_second_out (bus_second),
    .par_first_out  (par_first),
    .par_second_out (par_second)
  );

  fis_top uut (
    .ref_clk_in                  (ref_clk),
    .rst_in                      (rst),
    .hsel_in                     (hsel),
    .haddr_in                    (haddr),
    .htrans_in                   (htrans),
    .hwrite_in                   (hwrite),
    .hsize_in                    (hsize),
    .hwdata_in                   (hwdata),
    .hready_in                   (hreadyout),
    .hrdata_out                  (hrdata),
    .hreadyout_out               (hreadyout),
    .hresp_out                   (hresp),
    .irq_out                     (irq),
    .operand_bus_first_in        (bus_first),
    .operand_bus_second_in       (bus_second),
    .first_bus_parity_in         (par_first),
    .second_bus_parity_in        (par_second),
    .first_bus_parity_fault_out  (fault_first),
    .second_bus_parity_fault_out (fault_second),
    .operand_reg_first_out       (op_first),
    .operand_reg_second_out      (op_second),
    .staged_out                  (staged)
  );

  // Verdict and end of run
  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic seen;
    int   n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(negedge ref_clk);
      seen = hreadyout;
      @(posedge ref_clk);
      n++;
    end while (seen !== 1'b1 && n < 40);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do begin
      @(negedge ref_clk);
      seen = hreadyout;
      rd   = hrdata;
      @(posedge ref_clk);
      n++;
    end while (seen !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check({32'h0, r}, {32'h0, exp});
  endtask

  // Control fields: bypass, routing, edge select, granularity
  task automatic set_ctrl(input logic gran, input logic edge_sel,
                          input logic [1:0] route, input logic bypass);
    wr(ADDR_CTRL, {27'h0, bypass, route, edge_sel, gran});
  endtask

  // Operand halves for each routing code, A then B
  function automatic logic [127:0] route_exp(input logic [1:0] r,
      input logic [31:0] f, input logic [31:0] s, input logic [63:0] t);
    case (r)
      2'b00:   return {f, s, t};
      2'b01:   return {f, t[63:32], s, t[31:0]};
      2'b10:   return {t[63:32], f, t[31:0], s};
      default: return {t, f, s};
    endcase
  endfunction

  // Cuts a hang short
  initial begin
    #200000;
    failures++;
    final_report();
  end

  // Main sequence
  initial begin
    ref_clk  = 1'b0;
    rst      = 1'b1;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = HTRANS_IDLE;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    failures = 0;
    checks   = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values and unmapped space
    rdc(ADDR_CTRL, 32'h4);
    rdc(ADDR_STATUS, 32'h0);
    rdc(ADDR_ENABLE, 32'h0);
    rdc(ADDR_CLEAR, 32'h0);
    rdc(8'h10, 32'h0);
    check(hresp, HRESP_OKAY);
    check(irq, 1'b0);
    // Parity faults per bus in byte then word granularity
    for (int g = 1; g >= 0; g--) begin
      set_ctrl(g[0], 1'b0, 2'b01, 1'b0);
      for (int i = 0; i < 8; i++) begin
        // Clean cycle first so each flip starts from no fault
        host.drive(32'h13f0a581, 32'h7e2c0040, g[0], 4'h0, 4'h0);
        @(posedge ref_clk);
        host.drive(32'h13f0a581, 32'h7e2c0040, g[0],
                   (i < 4) ? 4'h1 << i : 4'h0,
                   (i < 4) ? 4'h0 : 4'h1 << (i - 4));
        @(negedge ref_clk);
        check(fault_first, i < 4 && (g == 1 || i == 0));
        check(fault_second, i >= 4 && (g == 1 || i == 4));
        @(posedge ref_clk);
      end
      host.drive(32'h13f0a581, 32'h7e2c0040, g[0], 4'h0, 4'h0);
      @(negedge ref_clk);
      check({fault_first, fault_second}, 2'b00);
      @(posedge ref_clk);
    end
    // Routing codes: staged first clock, buses second clock
    for (int r = 0; r < 4; r++) begin
      set_ctrl(1'b0, 1'b0, r[1:0], 1'b0);
      host.drive(32'ha1b2c3d4 + r, 32'h05060708, 1'b0, 4'h0, 4'h0);
      @(posedge ref_clk);
      host.drive(32'h99887766, 32'h1122334f - r, 1'b0, 4'h0, 4'h0);
      @(posedge ref_clk);
      @(negedge ref_clk);
      exp_ops = route_exp(r[1:0], 32'h99887766, 32'h1122334f - r,
                          {32'ha1b2c3d4 + r, 32'h05060708});
      check(op_first, exp_ops[127:64]);
      check(op_second, exp_ops[63:0]);
      check(staged, {32'h99887766, 32'h1122334f - r});
      @(posedge ref_clk);
    end
    // Falling edge capture: staged follows data within the cycle
    set_ctrl(1'b0, 1'b1, 2'b00, 1'b0);
    host.drive(32'hcafe0123, 32'h0badf00d, 1'b0, 4'h0, 4'h0);
    @(negedge ref_clk);
    #1;
    check(staged, 64'hcafe01230badf00d);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check(op_second, 64'hcafe01230badf00d);
    @(posedge ref_clk);
    // Input bypass: operand upper halves follow the buses in the same cycle
    set_ctrl(1'b0, 1'b0, 2'b01, 1'b1);
    host.drive(32'h10203040, 32'h50607080, 1'b0, 4'h0, 4'h0);
    @(posedge ref_clk);
    host.drive(32'h0f0e0d0c, 32'h0b0a0908, 1'b0, 4'h0, 4'h0);
    @(negedge ref_clk);
    check(op_first, 64'h0f0e0d0c10203040);
    check(op_second, 64'h0b0a090850607080);
    @(posedge ref_clk);
    // Pair routing in bypass: A follows both buses at once
    set_ctrl(1'b0, 1'b0, 2'b00, 1'b1);
    @(negedge ref_clk);
    check(op_first, 64'h0f0e0d0c0b0a0908);
    @(posedge ref_clk);
    // Sticky status, masking and clearing of the interrupt
    wr(ADDR_CLEAR, 32'h3);
    rdc(ADDR_STATUS, 32'h0);
    host.drive(32'h0f0e0d0c, 32'h0b0a0908, 1'b0, 4'h0, 4'h1);
    @(posedge ref_clk);
    host.drive(32'h0f0e0d0c, 32'h0b0a0908, 1'b0, 4'h0, 4'h0);
    @(posedge ref_clk);
    rdc(ADDR_STATUS, 32'h2);
    check(irq, 1'b0);
    wr(ADDR_ENABLE, 32'h2);
    @(negedge ref_clk);
    check(irq, 1'b1);
    @(posedge ref_clk);
    wr(ADDR_ENABLE, 32'h1);
    @(negedge ref_clk);
    check(irq, 1'b0);
    @(posedge ref_clk);
    wr(ADDR_STATUS, 32'h0);
    rdc(ADDR_STATUS, 32'h2);
    wr(ADDR_CLEAR, 32'h2);
    rdc(ADDR_STATUS, 32'h0);
    rdc(ADDR_ENABLE, 32'h1);
    final_report();
  end
endmodule
